// ### hw/bum_pkg.sv
// Shared constants, types and the quarter-wave table of the uplink modulator
// Assumes one 100 MHz system clock shared by both ends of the link

package bum_pkg;

  // --------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------
  localparam int CLK_HZ        = 100_000_000;
  localparam int SAMPLE_HZ     = 4_333_333;
  localparam int SAMPLE_DIV    = CLK_HZ / SAMPLE_HZ;
  localparam int PWR_SETTLE_NS = 10_000;
  localparam int PWR_SETTLE_CYC =
    (PWR_SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int CAL_STEP_NS   = 1_000;
  localparam int CAL_STEP_CYC  =
    (CAL_STEP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

  // --------------------------------------------------------------------
  // Burst and modulator shape
  // --------------------------------------------------------------------
  localparam int BURST_BITS       = 160;
  localparam int SAMPLES_PER_BIT  = 16;
  localparam int SAMPLES_PER_QBIT = 4;
  localparam int TAIL_QBITS       = 32;
  localparam int TAIL_SAMPLES     = TAIL_QBITS * SAMPLES_PER_QBIT;
  localparam int DAC_W            = 10;
  localparam int OFS_W            = 6;
  localparam int PHASE_W          = 6;
  localparam int QTR              = 16;
  localparam logic [DAC_W-1:0] I_IDLE = 10'h1ff;
  localparam logic [DAC_W-1:0] Q_IDLE = 10'h000;

  // --------------------------------------------------------------------
  // Control word fields
  // --------------------------------------------------------------------
  localparam int CTRL_W         = 9;
  localparam int FIELD3_W       = 3;
  localparam int CTRL_SLOT_BIT  = 5;
  localparam int CTRL_LEVEL_LSB = 6;
  localparam int CTRL_CM_LSB    = 0;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;

  // --------------------------------------------------------------------
  // Serial port framing
  // --------------------------------------------------------------------
  localparam int WORD_W        = 16;
  localparam int WORD_CTRL_BIT = 15;
  localparam int WORD_BUF_BIT  = 8;
  localparam int BYTE_W        = 8;
  localparam int BYTES_PER_BUF = BURST_BITS / BYTE_W;
  localparam int FIFO_DEPTH    = 8;
  localparam int BSP_GAP       = 8;
  localparam int TSP_BITS      = 3;
  localparam int TSP_GAP       = 4;

  // --------------------------------------------------------------------
  // Types and tables
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {BUM_IDLE, BUM_MOD, BUM_TAIL} bum_mod_e;

  localparam logic [QTR:0][DAC_W-1:0] COS_ROM = {
    10'h000, 10'h032, 10'h064, 10'h094, 10'h0c4, 10'h0f1, 10'h11c,
    10'h144, 10'h169, 10'h18b, 10'h1a9, 10'h1c3, 10'h1d8, 10'h1e9,
    10'h1f5, 10'h1fc, 10'h1ff};

  function automatic logic [DAC_W-1:0] bum_cos(input logic [PHASE_W-1:0] p);
    logic [4:0] k;
    logic [4:0] kr;
    k  = {1'b0, p[3:0]};
    kr = 5'(QTR) - k;
    case (p[5:4])
      2'd0:    return COS_ROM[k];
      2'd1:    return -COS_ROM[kr];
      2'd2:    return -COS_ROM[k];
      default: return COS_ROM[kr];
    endcase
  endfunction

endpackage

// ### hw/bum_link_if.sv
// Link between the processor end and the modulator end
// Assumes both ends run on the same system clock
`timescale 1ns/1ps

interface bum_link_if;
  logic bsp_fsync;
  logic bsp_data;
  logic bsp_hold;
  logic tsp_en;
  logic tsp_data;

  modport dev  (input  bsp_fsync, bsp_data, tsp_en, tsp_data,
                output bsp_hold);
  modport host (output bsp_fsync, bsp_data, tsp_en, tsp_data,
                input  bsp_hold);
endinterface

// ### hw/bum_device.sv
// Modulator end: burst buffers, GMSK modulator, calibration, port decoders
// Assumes link pins are foreign and comparator inputs are asynchronous
//
// What this block does
// - Processor sends burst bits before transmission
// - ROM lookup on 4-bit window, 16 samples/bit
// - I/Q words at 4.33 MHz to 10-bit DACs
// - Whole burst held in 160-bit buffer
// - Multislot: fill one buffer, modulate other
// - Control bit 5 picks single or multislot
// - Control bits 8-6 set output level
// - Control bits 2-0 set common mode
// - Sequence: power up, calibrate, modulate
// - Three timing windows arrive over timing port
// - Power window rising powers path after settling
// - Calibration zeroes words, comparator trims offsets
// - Offset registers drive 6-bit correction sub-DACs
// - Calibration window covers full sub-DAC sweep
// - Modulate from enable rise to 32 quarter-bits after
// - Burst end returns pointers to base
// - After burst I is maximum, Q zero
// - Timing port: enable plus data, half clock
// - Baseband port: framed 16-bit words
`timescale 1ns/1ps

module bum_fifo #(
  parameter int W = 16,
  parameter int D = 8
) (
  // Clock and reset
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_nrst,
  input  wire logic                 i_ce,
  // Fill side
  input  wire logic                 i_in_valid,
  input  wire logic [W-1:0]         i_in_data,
  output logic                      o_in_ready,
  // Drain side
  output logic                      o_out_valid,
  output logic [W-1:0]              o_out_data,
  input  wire logic                 i_out_ready,
  output logic [$clog2(D):0]        o_level
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       rd;
    logic [AW-1:0]       wr;
    logic [AW:0]         cnt;
  } bum_fifo_s;

  bum_fifo_s q;
  bum_fifo_s d;
  logic      push;
  logic      pop;

  assign o_in_ready  = q.cnt != (AW+1)'(D);
  assign o_out_valid = q.cnt != '0;
  assign o_out_data  = q.mem[q.rd];
  assign o_level     = q.cnt;
  assign push        = i_in_valid && o_in_ready;
  assign pop         = i_out_ready && o_out_valid;

  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wr] = i_in_data;
      d.wr        = (q.wr == AW'(D-1)) ? '0 : q.wr + 1'b1;
    end
    if (pop) begin
      d.rd = (q.rd == AW'(D-1)) ? '0 : q.rd + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end
endmodule // bum_fifo

module bum_device
  import bum_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic               i_sys_clk,
  input  wire logic               i_nrst,
  input  wire logic               i_ce,
  // Link
  bum_link_if.dev                 link,
  // Analog side
  input  wire logic [1:0]         i_cmp_high,
  output logic [DAC_W-1:0]        o_i_word,
  output logic [DAC_W-1:0]        o_q_word,
  output logic                    o_sample_strobe,
  output logic [OFS_W-1:0]        o_offset_i,
  output logic [OFS_W-1:0]        o_offset_q,
  output logic [FIELD3_W-1:0]     o_output_level,
  output logic [FIELD3_W-1:0]     o_common_mode,
  // Status
  output logic                    o_path_powered,
  output logic                    o_cal_active,
  output logic                    o_modulating
);
  localparam int SW = $clog2(PWR_SETTLE_CYC + 1);
  localparam int CW = $clog2(CAL_STEP_CYC + 1);
  localparam int LW = $clog2(DEPTH) + 1;

  typedef struct packed {
    logic [1:0]                     s_ten;
    logic [1:0]                     s_tdr;
    logic [1:0]                     s_fs;
    logic [1:0]                     s_bd;
    logic [1:0]                     s_cmp1;
    logic [1:0]                     s_cmp2;
    logic                           half;
    logic                           ten_prev;
    logic [TSP_BITS-1:0]            ts_sr;
    logic [2:0]                     ts_cnt;
    logic                           win_pwr;
    logic                           win_cal;
    logic                           win_mod;
    logic                           mod_prev;
    logic                           rx_on;
    logic [3:0]                     rx_cnt;
    logic [WORD_W-1:0]              rx_sr;
    logic                           rx_push;
    logic [CTRL_W-1:0]              ctrl;
    logic [1:0][BURST_BITS-1:0]     bbuf;
    logic [1:0][4:0]                wp;
    logic [SW-1:0]                  settle;
    logic                           powered;
    logic [CW-1:0]                  cal_cnt;
    logic [1:0][OFS_W-1:0]          ofs;
    bum_mod_e                       st;
    logic                           act;
    logic                           next_buf;
    logic [7:0]                     bit_ptr;
    logic [3:0]                     sub;
    logic [4:0]                     div;
    logic [3:0]                     win4;
    logic [PHASE_W-1:0]             base;
    logic [7:0]                     tail;
    logic [DAC_W-1:0]               i_word;
    logic [DAC_W-1:0]               q_word;
    logic                           strobe;
    logic                           hold;
    logic                           cal_out;
    logic                           mod_out;
  } bum_dev_s;

  bum_dev_s                 q;
  bum_dev_s                 d;
  logic                     f_valid;
  logic                     f_ready;
  logic [WORD_W-1:0]        f_data;
  logic                     f_in_ready;
  logic [LW-1:0]            f_level;
  logic                     f_sel;

  assign f_sel   = f_data[WORD_BUF_BIT];
  // Stall writes into the buffer that is being modulated
  assign f_ready = f_data[WORD_CTRL_BIT] || q.st == BUM_IDLE ||
                   f_sel != q.act;

  bum_fifo #(.W(WORD_W), .D(DEPTH)) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_nrst      (i_nrst),
    .i_ce        (i_ce),
    .i_in_valid  (q.rx_push),
    .i_in_data   (q.rx_sr),
    .o_in_ready  (f_in_ready),
    .o_out_valid (f_valid),
    .o_out_data  (f_data),
    .i_out_ready (f_ready),
    .o_level     (f_level)
  );

  always_comb begin
    logic                 dir;
    logic                 tick;
    logic [PHASE_W-1:0]   ph;
    logic [7:0]           bidx;
    dir  = q.win4[1] ^ q.win4[2];
    tick = q.div == 5'(SAMPLE_DIV - 1);
    ph   = '0;
    bidx = '0;
    d    = q;
    d.rx_push = 1'b0;
    d.strobe  = 1'b0;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    d.s_ten  = {q.s_ten[0], link.tsp_en};
    d.s_tdr  = {q.s_tdr[0], link.tsp_data};
    d.s_fs   = {q.s_fs[0], link.bsp_fsync};
    d.s_bd   = {q.s_bd[0], link.bsp_data};
    d.s_cmp1 = i_cmp_high;
    d.s_cmp2 = q.s_cmp1;

    // ------------------------------------------------------------------
    // Timing port: 3 bits {power, cal, mod}, one per two clocks
    // ------------------------------------------------------------------
    d.half     = ~q.half;
    d.ten_prev = q.s_ten[1];
    if (q.s_ten[1] && q.half) begin
      d.ts_sr  = {q.ts_sr[TSP_BITS-2:0], q.s_tdr[1]};
      d.ts_cnt = (q.ts_cnt == 3'd7) ? q.ts_cnt : q.ts_cnt + 1'b1;
    end
    if (q.ten_prev && !q.s_ten[1]) begin
      if (q.ts_cnt == 3'(TSP_BITS)) begin
        {d.win_pwr, d.win_cal, d.win_mod} = q.ts_sr;
      end
      d.ts_cnt = '0;
    end

    // ------------------------------------------------------------------
    // Baseband port receiver, framed 16-bit words, MSB first
    // ------------------------------------------------------------------
    if (!q.rx_on) begin
      if (q.s_fs[1]) begin
        d.rx_on  = 1'b1;
        d.rx_sr  = {{(WORD_W-1){1'b0}}, q.s_bd[1]};
        d.rx_cnt = 4'd1;
      end
    end else begin
      d.rx_sr  = {q.rx_sr[WORD_W-2:0], q.s_bd[1]};
      d.rx_cnt = q.rx_cnt + 1'b1;
      if (q.rx_cnt == 4'(WORD_W - 1)) begin
        d.rx_on   = 1'b0;
        d.rx_push = f_in_ready;
      end
    end
    d.hold = f_level >= LW'(DEPTH - 1);

    // ------------------------------------------------------------------
    // Word sink: control register or burst byte
    // ------------------------------------------------------------------
    if (f_valid && f_ready) begin
      if (f_data[WORD_CTRL_BIT]) begin
        d.ctrl = f_data[CTRL_W-1:0];
      end else begin
        bidx = {q.wp[f_sel], 3'b000};
        d.bbuf[f_sel][bidx +: BYTE_W] = f_data[BYTE_W-1:0];
        d.wp[f_sel] = (q.wp[f_sel] == 5'(BYTES_PER_BUF - 1)) ?
                      '0 : q.wp[f_sel] + 1'b1;
      end
    end

    // ------------------------------------------------------------------
    // Power-up settling
    // ------------------------------------------------------------------
    if (!q.win_pwr) begin
      d.powered = 1'b0;
      d.settle  = '0;
    end else if (!q.powered) begin
      d.settle = q.settle + 1'b1;
      if (q.settle == SW'(PWR_SETTLE_CYC - 1)) begin
        d.powered = 1'b1;
      end
    end

    // ------------------------------------------------------------------
    // Offset calibration, one sub-DAC step per interval
    // ------------------------------------------------------------------
    if (q.win_cal && q.powered && q.st == BUM_IDLE) begin
      d.i_word  = '0;
      d.q_word  = '0;
      d.cal_cnt = q.cal_cnt + 1'b1;
      if (q.cal_cnt == CW'(CAL_STEP_CYC - 1)) begin
        d.cal_cnt = '0;
        for (int ch = 0; ch < 2; ch++) begin
          if (q.s_cmp2[ch] && q.ofs[ch] != '0) begin
            d.ofs[ch] = q.ofs[ch] - 1'b1;
          end else if (!q.s_cmp2[ch] && q.ofs[ch] != '1) begin
            d.ofs[ch] = q.ofs[ch] + 1'b1;
          end
        end
      end
    end else begin
      d.cal_cnt = '0;
    end

    // ------------------------------------------------------------------
    // Modulator
    // ------------------------------------------------------------------
    d.mod_prev = q.win_mod;
    d.div      = (q.st == BUM_IDLE || tick) ? '0 : q.div + 1'b1;
    case (q.st)
      BUM_IDLE: begin
        if (q.win_mod && !q.mod_prev && q.powered) begin
          d.st      = BUM_MOD;
          d.act     = q.ctrl[CTRL_SLOT_BIT] ? q.next_buf : 1'b0;
          d.bit_ptr = '0;
          d.sub     = '0;
          d.base    = '0;
          d.win4    = '0;
        end
      end
      BUM_MOD, BUM_TAIL: begin
        if (q.st == BUM_MOD && !q.win_mod) begin
          d.st   = BUM_TAIL;
          d.tail = '0;
        end
        if (tick) begin
          ph       = dir ? q.base + PHASE_W'(q.sub) :
                           q.base - PHASE_W'(q.sub);
          d.i_word = bum_cos(ph);
          d.q_word = bum_cos(ph - PHASE_W'(QTR));
          d.strobe = 1'b1;
          d.sub    = q.sub + 1'b1;
          if (q.sub == 4'(SAMPLES_PER_BIT - 1)) begin
            d.base = dir ? q.base + PHASE_W'(SAMPLES_PER_BIT) :
                           q.base - PHASE_W'(SAMPLES_PER_BIT);
            d.win4 = {q.win4[2:0], q.bbuf[q.act][q.bit_ptr]};
            if (q.bit_ptr != 8'(BURST_BITS - 1)) begin
              d.bit_ptr = q.bit_ptr + 1'b1;
            end
          end
          if (q.st == BUM_TAIL) begin
            d.tail = q.tail + 1'b1;
            if (q.tail == 8'(TAIL_SAMPLES - 1)) begin
              d.st       = BUM_IDLE;
              d.bit_ptr  = '0;
              d.sub      = '0;
              d.base     = '0;
              d.wp[q.act] = '0;
              d.i_word   = I_IDLE;
              d.q_word   = Q_IDLE;
              d.next_buf = q.ctrl[CTRL_SLOT_BIT] ? ~q.act : 1'b0;
            end
          end
        end
      end
      default: begin
        d.st = BUM_IDLE;
      end
    endcase
    d.cal_out = d.win_cal && d.powered && d.st == BUM_IDLE;
    d.mod_out = d.st != BUM_IDLE;
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q        <= '0;
      q.ctrl   <= CTRL_RESET;
      q.st     <= BUM_IDLE;
      q.i_word <= I_IDLE;
      q.q_word <= Q_IDLE;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign link.bsp_hold   = q.hold;
  assign o_i_word        = q.i_word;
  assign o_q_word        = q.q_word;
  assign o_sample_strobe = q.strobe;
  assign o_offset_i      = q.ofs[0];
  assign o_offset_q      = q.ofs[1];
  assign o_output_level  = q.ctrl[CTRL_LEVEL_LSB +: FIELD3_W];
  assign o_common_mode   = q.ctrl[CTRL_CM_LSB +: FIELD3_W];
  assign o_path_powered  = q.powered;
  assign o_cal_active    = q.cal_out;
  assign o_modulating    = q.mod_out;
endmodule // bum_device

// ### hw/bum_host.sv
// Processor end: serialises burst/control words and timing window frames
// Assumes the device end shares this clock; hold arrives from its flop
`timescale 1ns/1ps

module bum_host
  import bum_pkg::*;
(
  // Clock and reset
  input  wire logic                i_sys_clk,
  input  wire logic                i_nrst,
  input  wire logic                i_ce,
  // Link
  bum_link_if.host                 link,
  // Word request
  input  wire logic                i_word_valid,
  input  wire logic [WORD_W-1:0]   i_word,
  output logic                     o_word_ready,
  // Window request {power, cal, mod}
  input  wire logic                i_rt_valid,
  input  wire logic [TSP_BITS-1:0] i_rt_bits,
  output logic                     o_rt_ready
);
  typedef struct packed {
    logic                b_busy;
    logic [4:0]          b_cnt;
    logic [WORD_W-1:0]   b_sr;
    logic                b_ready;
    logic                fsync;
    logic                bdata;
    logic                t_busy;
    logic [3:0]          t_cnt;
    logic [TSP_BITS-1:0] t_sr;
    logic                t_ready;
    logic                timing_port_enable;
    logic                timing_port_data_in;
  } bum_host_s;

  bum_host_s q;
  bum_host_s d;

  always_comb begin
    d       = q;
    d.fsync = 1'b0;

    // ------------------------------------------------------------------
    // Baseband port: 16 bits MSB first, then a gap, then hold check
    // ------------------------------------------------------------------
    if (!q.b_busy) begin
      d.b_ready = !link.bsp_hold;
      if (i_word_valid && q.b_ready) begin
        d.b_busy  = 1'b1;
        d.b_ready = 1'b0;
        d.b_cnt   = '0;
        d.b_sr    = {i_word[WORD_W-2:0], 1'b0};
        d.bdata   = i_word[WORD_W-1];
        d.fsync   = 1'b1;
      end
    end else begin
      d.b_cnt = q.b_cnt + 1'b1;
      if (q.b_cnt < 5'(WORD_W - 1)) begin
        d.bdata = q.b_sr[WORD_W-1];
        d.b_sr  = {q.b_sr[WORD_W-2:0], 1'b0};
      end else begin
        d.bdata = 1'b0;
      end
      if (q.b_cnt == 5'(WORD_W - 1 + BSP_GAP)) begin
        d.b_busy = 1'b0;
      end
    end

    // ------------------------------------------------------------------
    // Timing port: each window bit stands two clocks
    // ------------------------------------------------------------------
    if (!q.t_busy) begin
      d.t_ready = 1'b1;
      if (i_rt_valid && q.t_ready) begin
        d.t_busy  = 1'b1;
        d.t_ready = 1'b0;
        d.t_cnt   = '0;
        d.timing_port_enable     = 1'b1;
        d.timing_port_data_in     = i_rt_bits[TSP_BITS-1];
        d.t_sr    = {i_rt_bits[TSP_BITS-2:0], 1'b0};
      end
    end else begin
      d.t_cnt = q.t_cnt + 1'b1;
      if (q.t_cnt[0]) begin
        d.timing_port_data_in  = q.t_sr[TSP_BITS-1];
        d.t_sr = {q.t_sr[TSP_BITS-2:0], 1'b0};
      end
      if (q.t_cnt == 4'(2 * TSP_BITS - 1)) begin
        d.timing_port_enable = 1'b0;
        d.timing_port_data_in = 1'b0;
      end
      if (q.t_cnt == 4'(2 * TSP_BITS - 1 + TSP_GAP)) begin
        d.t_busy = 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign link.bsp_fsync = q.fsync;
  assign link.bsp_data  = q.bdata;
  assign link.tsp_en    = q.timing_port_enable;
  assign link.tsp_data  = q.timing_port_data_in;
  assign o_word_ready   = q.b_ready;
  assign o_rt_ready     = q.t_ready;
endmodule // bum_host

// ### tb/bum_checker.sv
// Link checker: framing and pacing of both serial ports
// Assumes it sits beside the link interface on the one system clock
`timescale 1ns/1ps

module bum_checker (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  // Link signals
  input wire logic bsp_fsync,
  input wire logic bsp_data,
  input wire logic bsp_hold,
  input wire logic tsp_en,
  input wire logic tsp_data
);
  // --------------------------------------------------------------------
  // Cycles since last word start
  // --------------------------------------------------------------------
  logic [5:0] gap_q;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) gap_q <= 6'h3f;
    else if (bsp_fsync) gap_q <= 6'h00;
    else if (gap_q != 6'h3f) gap_q <= gap_q + 6'h01;
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  sequence s_word_tail;
    ##16 (!bsp_data)[*8];
  endsequence
  sequence s_tsp_frame;
    tsp_en[*6] ##1 !tsp_en;
  endsequence
  sequence s_tsp_bits;
    ##1 $stable(tsp_data) ##2 $stable(tsp_data) ##2 $stable(tsp_data);
  endsequence

  chk_fsync_one_cycle: assert property (bsp_fsync |=> !bsp_fsync)
    else $error("word start longer than one cycle");
  chk_fsync_spacing: assert property (bsp_fsync |-> gap_q >= 6'h18)
    else $error("word starts too close");
  chk_word_tail: assert property (bsp_fsync |-> s_word_tail)
    else $error("word gap not low");
  chk_hold_blocks: assert property (bsp_hold[*3] |=> !bsp_fsync)
    else $error("word sent while held");
  chk_tsp_frame: assert property ($rose(tsp_en) |-> s_tsp_frame)
    else $error("timing frame length wrong");
  chk_tsp_bit_hold: assert property ($rose(tsp_en) |-> s_tsp_bits)
    else $error("timing bit not held two cycles");
  chk_tsp_gap: assert property ($fell(tsp_en) |-> (!tsp_en)[*4])
    else $error("timing frame gap short");
  chk_tsp_idle: assert property (!tsp_en |-> !tsp_data)
    else $error("timing data not idle low");
endmodule // bum_checker

// ### tb/test_burst_uplink_gmsk_modulator.sv
// Testbench: host end and modulator end joined by the link interface
// Assumes the design package, interface and both ends are compiled first
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end

module test_burst_uplink_gmsk_modulator
  import bum_pkg::*;
();
  // --------------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------------
  logic i_sys_clk = 1'b0, i_nrst = 1'b0, i_ce = 1'b1;
  logic i_word_valid = 1'b0, i_rt_valid = 1'b0, hold_seen = 1'b0;
  logic [WORD_W-1:0] i_word = 16'h0000;
  logic [TSP_BITS-1:0] i_rt_bits = 3'h0;
  logic [1:0] i_cmp_high = 2'h0;
  logic o_word_ready, o_rt_ready, o_sample_strobe;
  logic o_path_powered, o_cal_active, o_modulating;
  logic [DAC_W-1:0] o_i_word, o_q_word;
  logic [OFS_W-1:0] o_offset_i, o_offset_q;
  logic [FIELD3_W-1:0] o_output_level, o_common_mode;
  logic [15:0] lfsr_q = 16'h73dd;
  int errors = 0, samples_checked = 0, cyc = 0, tail;
  int times[$];

  always #5 i_sys_clk = ~i_sys_clk;

  // --------------------------------------------------------------------
  // Design and checker
  // --------------------------------------------------------------------
  bum_link_if link ();
  bum_host i_bum_host (.i_sys_clk, .i_nrst, .i_ce, .link(link),
    .i_word_valid, .i_word, .o_word_ready, .i_rt_valid, .i_rt_bits,
    .o_rt_ready);
  bum_device #(.DEPTH(FIFO_DEPTH)) i_bum_device (.i_sys_clk, .i_nrst, .i_ce,
    .link(link), .i_cmp_high, .o_i_word, .o_q_word, .o_sample_strobe,
    .o_offset_i, .o_offset_q, .o_output_level, .o_common_mode,
    .o_path_powered, .o_cal_active, .o_modulating);
  bum_checker i_bum_checker (.i_sys_clk, .i_nrst,
    .bsp_fsync(link.bsp_fsync), .bsp_data(link.bsp_data),
    .bsp_hold(link.bsp_hold), .tsp_en(link.tsp_en),
    .tsp_data(link.tsp_data));

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  function automatic void rnd();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
  endfunction

  function automatic int rom_idx(input logic [DAC_W-1:0] v);
    logic [DAC_W-1:0] m;
    m = v[DAC_W-1] ? -v : v;
    rom_idx = -1;
    for (int k = 0; k <= QTR; k++) begin
      if (COS_ROM[k] == m) rom_idx = k;
    end
  endfunction

  task automatic send_word(input logic [WORD_W-1:0] w);
    @(negedge i_sys_clk);
    i_word = w;
    while (o_word_ready !== 1'b1) @(negedge i_sys_clk);
    i_word_valid = 1'b1;
    @(negedge i_sys_clk);
    i_word_valid = 1'b0;
  endtask

  task automatic send_rt(input logic [TSP_BITS-1:0] b);
    @(negedge i_sys_clk);
    i_rt_bits = b;
    while (o_rt_ready !== 1'b1) @(negedge i_sys_clk);
    i_rt_valid = 1'b1;
    @(negedge i_sys_clk);
    i_rt_valid = 1'b0;
    repeat (16) @(negedge i_sys_clk);
  endtask

  task automatic burst(input logic ms, input logic [WORD_W-1:0] wbuf);
    logic [CTRL_W-1:0] c;
    rnd();
    c = lfsr_q[CTRL_W-1:0];
    c[CTRL_SLOT_BIT] = ms;
    send_word({1'b1, 6'h00, c});
    repeat (40) @(negedge i_sys_clk);
    `CHK(o_output_level, c[8:6])
    `CHK(o_common_mode, c[2:0])
    hold_seen = 1'b0;
    send_rt(3'b101);
    `CHK(o_modulating, 1'b1)
    fork
      for (int k = 0; k < 10; k++) begin
        rnd();
        i_cmp_high = lfsr_q[9:8];
        send_word(wbuf | {8'h00, lfsr_q[7:0]});
      end
      begin
        repeat (600) @(negedge i_sys_clk);
        send_rt(3'b100);
        tail = 0;
        while (o_modulating === 1'b1) begin
          @(negedge i_sys_clk);
          if (o_sample_strobe === 1'b1) tail++;
        end
        `CHK(tail >= TAIL_SAMPLES - 1 && tail <= TAIL_SAMPLES, 1'b1)
        `CHK(o_i_word, I_IDLE)
        `CHK(o_q_word, Q_IDLE)
      end
    join
    `CHK(hold_seen, !ms)
    repeat (40) @(negedge i_sys_clk);
    `CHK(link.bsp_hold, 1'b0)
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Monitors and timeout
  // --------------------------------------------------------------------
  always @(negedge i_sys_clk) begin
    if (link.bsp_hold === 1'b1 && o_modulating === 1'b1) hold_seen = 1'b1;
    if (o_modulating !== 1'b1) times.delete();
    else if (o_sample_strobe === 1'b1) begin
      if (times.size() == 0) `CHK(o_i_word, I_IDLE)
      `CHK(rom_idx(o_i_word) + rom_idx(o_q_word), QTR)
      times.push_back(cyc);
      if (times.size() > 1) `CHK(times[$] - times[$-1], SAMPLE_DIV)
    end
  end

  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc > 40000) begin
      errors++;
      summarize();
    end
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (2) @(negedge i_sys_clk);
    i_nrst = 1'b1;
    `CHK(o_i_word, I_IDLE)
    `CHK(o_q_word, Q_IDLE)
    `CHK(o_offset_i, 6'h00)
    `CHK(o_path_powered, 1'b0)
    $display("test reset done");
    for (int k = 0; k < BYTES_PER_BUF; k++) begin
      rnd();
      send_word({8'h00, lfsr_q[7:0]});
    end
    send_rt(3'b100);
    repeat (980) @(negedge i_sys_clk);
    `CHK(o_path_powered, 1'b0)
    repeat (40) @(negedge i_sys_clk);
    `CHK(o_path_powered, 1'b1)
    $display("test power done");
    i_cmp_high = 2'b01;
    send_rt(3'b110);
    `CHK(o_cal_active, 1'b1)
    `CHK(o_i_word, 10'h000)
    `CHK(o_q_word, 10'h000)
    repeat (6600) @(negedge i_sys_clk);
    `CHK(o_offset_i, 6'h00)
    `CHK(o_offset_q, 6'h3f)
    i_cmp_high = 2'b10;
    repeat (1000) @(negedge i_sys_clk);
    `CHK(o_offset_i == 6'h09 || o_offset_i == 6'h0a, 1'b1)
    `CHK(6'(o_offset_i + o_offset_q), 6'h3f)
    send_rt(3'b100);
    $display("test calibration done");
    burst(1'b1, 16'h0100);
    $display("test multislot burst done");
    burst(1'b0, 16'h0000);
    $display("test single slot burst done");
    summarize();
  end
endmodule // test_burst_uplink_gmsk_modulator
